// *** common/rsc_defs.vh ***
/*
 Shared constants of the reset source combiner: register offsets,
 status bit positions, masks and reset values.
 Assumes inclusion by bare name from the design files under verilog/.
*/
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

// Register bus geometry
`define RSC_ADDR_W 4
`define RSC_DATA_W 16

// Register offsets (word addresses on the plain port)
`define RSC_OFS_STATUS 4'h0
`define RSC_OFS_SOURCES 4'h1

// Bit positions inside reset_cause_status
`define RSC_B_TRAP 15
`define RSC_B_ILLOP 14
`define RSC_B_DSLP 10
`define RSC_B_CFGMM 9
`define RSC_B_PROGMEM_SLEEP_POWER 8
`define RSC_B_PIN 7
`define RSC_B_SWR 6
`define RSC_B_SOFT_WATCHDOG_ENABLE 5
`define RSC_B_WATCHDOG_TIMEOUT_FLAG 4
`define RSC_B_SLEEP 3
`define RSC_B_IDLE 2
`define RSC_B_BOR 1
`define RSC_B_POR 0

// Implemented bits: 13..11 always read as zero
`define RSC_STATUS_IMPL 16'hC7FF
// Value left by a power-on reset: only the two lowest flags set
`define RSC_STATUS_POR_VAL 16'h0003

// Live source vector width and zero constants
`define RSC_NSRC 9
`define RSC_ZERO16 16'h0000
`define RSC_OSC_W 3
`define RSC_OSC_RST 3'h0

`endif

// *** verilog/rsc_sync.v ***
/*
 Two-stage synchroniser for a group of asynchronous level inputs.
 Assumes levels held far longer than one CLK period.
*/
`timescale 1ns/10ps
module rsc_sync #(
	parameter W = 3
) (
	input wire CLK,
	input wire RST,
	input wire [W-1:0] D,
	output wire [W-1:0] Q
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// First stage feeds only the second stage
	always @(posedge CLK) begin
		if (RST) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= D;
			sync_q <= meta_q;
		end
	end

	assign Q = sync_q;
endmodule

// *** verilog/rsc_oscsel.v ***
/*
 Chooses the system clock source that applies after a reset.
 Assumes the fuse, switching enable and current field are static
 during a reset and sit in the CLK domain.
*/
`timescale 1ns/10ps
`include "rsc_defs.vh"
module rsc_oscsel (
	input wire CLK,
	input wire RST,
	input wire clk_switch_en,
	input wire por_bor,
	input wire other_rst,
	input wire [`RSC_OSC_W-1:0] fuse_sel,
	input wire [`RSC_OSC_W-1:0] cur_osc,
	output wire [`RSC_OSC_W-1:0] osc_sel,
	output wire osc_load
);
	reg [`RSC_OSC_W-1:0] sel_q;
	reg [`RSC_OSC_W-1:0] sel_d;
	reg active_q;
	reg load_q;
	wire any_rst;

	assign any_rst = por_bor | other_rst;

	// Power-up resets, or switching off, always go back to the fuses
	always @* begin
		sel_d = sel_q;
		if (any_rst) begin
			if (!clk_switch_en || por_bor) begin
				sel_d = fuse_sel;
			end else begin
				sel_d = cur_osc;
			end
		end
	end

	// Load pulse marks the cycle after the last reset source drops
	always @(posedge CLK) begin
		if (RST) begin
			sel_q <= `RSC_OSC_RST;
			active_q <= 1'b0;
			load_q <= 1'b0;
		end else begin
			sel_q <= sel_d;
			active_q <= any_rst;
			load_q <= active_q & ~any_rst;
		end
	end

	assign osc_sel = sel_q;
	assign osc_load = load_q;
endmodule

// *** verilog/rsc_top.v ***
/*
 Reset source combiner: merges every reset source into the master
 system reset, keeps the reset cause and power-save status register,
 and picks the clock source that applies after each reset.
 Assumes: pin-level sources are asynchronous and are synchronised
 here; core events arrive as one-cycle pulses or levels on CLK; the
 register port is driven by the core on CLK with one-cycle strobes.
*/
`timescale 1ns/10ps
`include "rsc_defs.vh"
module rsc_top (
	input wire CLK,
	input wire RST,
	// Pin-level reset sources, asynchronous
	input wire POWER_ON_DETECT,
	input wire BROWNOUT_DETECT,
	input wire MASTER_CLEAR_PIN_N,
	// Core event sources, CLK domain
	input wire SOFTWARE_RESET_INSTR,
	input wire WATCHDOG_TIMEOUT,
	input wire CONFIG_MISMATCH,
	input wire TRAP_CONFLICT,
	input wire ILLEGAL_OPCODE,
	input wire UNINIT_WREG_RESET,
	// Power-save instruction events, CLK domain
	input wire SLEEP_ENTER,
	input wire IDLE_ENTER,
	input wire DEEP_SLEEP_ENABLE,
	// Configuration fuses and oscillator state
	input wire WATCHDOG_FUSE_ENABLE,
	input wire CLOCK_SWITCH_ENABLE,
	input wire [`RSC_OSC_W-1:0] INITIAL_OSC_SELECT_FUSE,
	input wire [`RSC_OSC_W-1:0] CURRENT_OSC_FIELD,
	// Register port
	input wire [`RSC_ADDR_W-1:0] ADDR,
	input wire [`RSC_DATA_W-1:0] WDATA,
	input wire WR,
	input wire RD,
	output wire [`RSC_DATA_W-1:0] RDATA,
	// Results
	output wire MASTER_SYSTEM_RESET,
	output wire POR_ONLY_RESET,
	output wire WATCHDOG_ENABLE,
	output wire PROGMEM_SLEEP_POWER,
	output wire REGULATOR_STANDBY,
	output wire [`RSC_OSC_W-1:0] OSC_SELECT,
	output wire OSC_SELECT_LOAD
);

	// Address match, shared by the write and read decoders
	function hit;
		input [`RSC_ADDR_W-1:0] a;
		input [`RSC_ADDR_W-1:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	wire [2:0] pin_raw;
	wire [2:0] pin_sync;
	wire por_evt;
	wire bor_evt;
	wire pin_evt;
	wire illop_evt;
	wire power_save_instruction_evt;
	wire dslp_evt;
	wire any_src;
	wire other_src;
	wire wr_status;
	wire rd_status;
	wire rd_sources;
	wire [`RSC_NSRC-1:0] src_vec;

	reg [`RSC_DATA_W-1:0] stat_q;
	reg [`RSC_DATA_W-1:0] stat_d;
	reg [`RSC_DATA_W-1:0] rdata_q;
	reg [`RSC_DATA_W-1:0] rdata_d;
	reg master_system_reset_q;
	reg por_q;
	reg wdt_en_q;

	// The clear pin is active low; flip it before synchronising
	assign pin_raw = {~MASTER_CLEAR_PIN_N, BROWNOUT_DETECT,
		POWER_ON_DETECT};

	rsc_sync #(
		.W(3)
	) u_pin_sync (
		.CLK(CLK),
		.RST(RST),
		.D(pin_raw),
		.Q(pin_sync)
	);

	assign por_evt = pin_sync[0];
	assign bor_evt = pin_sync[1];
	assign pin_evt = pin_sync[2];
	assign illop_evt = ILLEGAL_OPCODE | UNINIT_WREG_RESET;

	// Either power-save flavour counts as the instruction executing
	assign power_save_instruction_evt = SLEEP_ENTER | IDLE_ENTER;
	assign dslp_evt = SLEEP_ENTER & DEEP_SLEEP_ENABLE;

	// Live view of every source, also visible to software
	assign src_vec = {UNINIT_WREG_RESET, ILLEGAL_OPCODE,
		TRAP_CONFLICT, CONFIG_MISMATCH, bor_evt, WATCHDOG_TIMEOUT,
		SOFTWARE_RESET_INSTR, pin_evt, por_evt};

	assign any_src = |src_vec;
	assign other_src = any_src & ~(por_evt | bor_evt);

	// Strobes qualified by address; RD and WR never coincide
	assign wr_status = WR & hit(ADDR, `RSC_OFS_STATUS);
	assign rd_status = RD & hit(ADDR, `RSC_OFS_STATUS);
	assign rd_sources = RD & hit(ADDR, `RSC_OFS_SOURCES);

	// Status next value. Order matters: software write first, then
	// hardware clears, then hardware sets, and power-on last.
	always @* begin
		stat_d = stat_q;
		if (wr_status) begin
			// Plain data, no reset side effect
			stat_d = WDATA & `RSC_STATUS_IMPL;
			// Deep-sleep flag can only be cleared by software
			stat_d[`RSC_B_DSLP] = stat_q[`RSC_B_DSLP] &
				WDATA[`RSC_B_DSLP];
		end
		// Power-save instruction clears the time-out flag
		if (power_save_instruction_evt) begin
			stat_d[`RSC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
		end
		// Sets come after the write so a same-cycle clear loses
		if (TRAP_CONFLICT) begin
			stat_d[`RSC_B_TRAP] = 1'b1;
		end
		if (illop_evt) begin
			stat_d[`RSC_B_ILLOP] = 1'b1;
		end
		if (dslp_evt) begin
			stat_d[`RSC_B_DSLP] = 1'b1;
		end
		if (CONFIG_MISMATCH) begin
			stat_d[`RSC_B_CFGMM] = 1'b1;
		end
		if (pin_evt) begin
			stat_d[`RSC_B_PIN] = 1'b1;
		end
		if (SOFTWARE_RESET_INSTR) begin
			stat_d[`RSC_B_SWR] = 1'b1;
		end
		if (WATCHDOG_TIMEOUT) begin
			stat_d[`RSC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
		end
		if (SLEEP_ENTER) begin
			stat_d[`RSC_B_SLEEP] = 1'b1;
		end
		if (IDLE_ENTER) begin
			stat_d[`RSC_B_IDLE] = 1'b1;
		end
		if (bor_evt) begin
			stat_d[`RSC_B_BOR] = 1'b1;
		end
		// Power-on wipes everything, control bits included
		if (por_evt) begin
			stat_d = `RSC_STATUS_POR_VAL;
		end
	end

	// Status register; block reset is treated as a power-on
	always @(posedge CLK) begin
		if (RST) begin
			stat_q <= `RSC_STATUS_POR_VAL;
		end else begin
			stat_q <= stat_d;
		end
	end

	// Read mux; unmapped or idle cycles return zero
	always @* begin
		rdata_d = `RSC_ZERO16;
		if (rd_status) begin
			rdata_d = stat_q & `RSC_STATUS_IMPL;
		end else if (rd_sources) begin
			rdata_d = {{(`RSC_DATA_W-`RSC_NSRC){1'b0}}, src_vec};
		end
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge CLK) begin
		if (RST) begin
			rdata_q <= `RSC_ZERO16;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Master reset and power-on-only reset are registered so they
	// never glitch when two sources overlap or hand over.
	always @(posedge CLK) begin
		if (RST) begin
			master_system_reset_q <= 1'b1;
			por_q <= 1'b1;
		end else begin
			master_system_reset_q <= any_src;
			por_q <= por_evt;
		end
	end

	// Fuse overrides the software enable; registered for a clean
	// level toward the watchdog counter.
	always @(posedge CLK) begin
		if (RST) begin
			wdt_en_q <= 1'b0;
		end else begin
			wdt_en_q <= WATCHDOG_FUSE_ENABLE |
				stat_q[`RSC_B_SOFT_WATCHDOG_ENABLE];
		end
	end

	// Clock source after reset, chosen by reset type
	rsc_oscsel u_oscsel (
		.CLK(CLK),
		.RST(RST),
		.clk_switch_en(CLOCK_SWITCH_ENABLE),
		.por_bor(por_evt | bor_evt),
		.other_rst(other_src),
		.fuse_sel(INITIAL_OSC_SELECT_FUSE),
		.cur_osc(CURRENT_OSC_FIELD),
		.osc_sel(OSC_SELECT),
		.osc_load(OSC_SELECT_LOAD)
	);

	// Bias and regulator behaviour in sleep follow bit 8 directly
	assign PROGMEM_SLEEP_POWER = stat_q[`RSC_B_PROGMEM_SLEEP_POWER];
	assign REGULATOR_STANDBY = ~stat_q[`RSC_B_PROGMEM_SLEEP_POWER];

	assign RDATA = rdata_q;
	assign MASTER_SYSTEM_RESET = master_system_reset_q;
	assign POR_ONLY_RESET = por_q;
	assign WATCHDOG_ENABLE = wdt_en_q;

endmodule

// *** dv/rsc_src_model.sv ***
/*
 Core side event model: turns a request into a one-cycle event pulse.
 Assumes go and sel are driven just after a rising CLK edge.
*/
`timescale 1ns/10ps
module rsc_src_model (
	input wire CLK,
	input wire go,
	input wire [2:0] sel,
	output reg [7:0] ev
);
	// Core events last one cycle, as a real instruction would
	initial ev = 8'h00;
	always @(posedge CLK) begin
		ev <= go ? (8'h01 << sel) : 8'h00;
	end
endmodule

// *** dv/rsc_checker.sv ***
/*
 Port checker of rsc_top, bound into every instance.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module rsc_checker (
	input wire CLK,
	input wire RST,
	input wire POWER_ON_DETECT,
	input wire BROWNOUT_DETECT,
	input wire MASTER_CLEAR_PIN_N,
	input wire SOFTWARE_RESET_INSTR,
	input wire WATCHDOG_TIMEOUT,
	input wire CONFIG_MISMATCH,
	input wire TRAP_CONFLICT,
	input wire ILLEGAL_OPCODE,
	input wire UNINIT_WREG_RESET,
	input wire WATCHDOG_FUSE_ENABLE,
	input wire CLOCK_SWITCH_ENABLE,
	input wire [2:0] INITIAL_OSC_SELECT_FUSE,
	input wire [2:0] CURRENT_OSC_FIELD,
	input wire [3:0] ADDR,
	input wire [15:0] WDATA,
	input wire WR,
	input wire RD,
	input wire [15:0] RDATA,
	input wire MASTER_SYSTEM_RESET,
	input wire WATCHDOG_ENABLE,
	input wire PROGMEM_SLEEP_POWER,
	input wire REGULATOR_STANDBY,
	input wire [2:0] OSC_SELECT,
	input wire OSC_SELECT_LOAD
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// Pins need five quiet samples to flush the synchroniser
	wire core = SOFTWARE_RESET_INSTR | WATCHDOG_TIMEOUT | CONFIG_MISMATCH
		| TRAP_CONFLICT | ILLEGAL_OPCODE | UNINIT_WREG_RESET;
	wire pb = POWER_ON_DETECT | BROWNOUT_DETECT;
	wire idle = !core & !pb & MASTER_CLEAR_PIN_N;
	a_core_reset: assert property (core |=> MASTER_SYSTEM_RESET)
		else $error("core source did not raise reset");
	a_reset_drop: assert property (idle [*5] |->
		!MASTER_SYSTEM_RESET)
		else $error("reset held with no source");
	a_write_quiet: assert property ((idle [*5]) ##0 WR |=>
		!MASTER_SYSTEM_RESET)
		else $error("status write caused a reset");
	a_gap_zero: assert property (RD && ADDR == 4'h0 |=>
		RDATA[13:11] == 3'h0)
		else $error("unimplemented bits read nonzero");
	a_bias_bit: assert property (WR && ADDR == 4'h0 && idle |=>
		PROGMEM_SLEEP_POWER == $past(WDATA[8])
		&& REGULATOR_STANDBY != $past(WDATA[8]))
		else $error("bias control not following bit 8");
	a_fuse_wdt: assert property (WATCHDOG_FUSE_ENABLE |=>
		WATCHDOG_ENABLE)
		else $error("fuse did not force watchdog");
	a_osc_keep: assert property (CLOCK_SWITCH_ENABLE && !pb &&
		(SOFTWARE_RESET_INSTR | WATCHDOG_TIMEOUT) |=>
		OSC_SELECT == $past(CURRENT_OSC_FIELD))
		else $error("clock choice not kept");
	a_load_end: assert property (OSC_SELECT_LOAD |->
		$fell(MASTER_SYSTEM_RESET))
		else $error("load pulse away from reset end");
	a_osc_fuse: assert property (!CLOCK_SWITCH_ENABLE &&
		TRAP_CONFLICT |=> OSC_SELECT == $past(INITIAL_OSC_SELECT_FUSE))
		else $error("clock choice not from fuses");
	cover property (TRAP_CONFLICT);
	cover property (OSC_SELECT_LOAD);
	cover property (WR && idle);
endmodule
bind rsc_top rsc_checker u_chk (.*);

// *** dv/test_rsc_top.sv ***
/*
 Self-checking bench of rsc_top: a status model compared at every status read.
 Assumes rsc_defs.vh on the include path and the event model beside.
*/
`timescale 1ns/10ps
module test_rsc_top;
	// Event k bit position, k = 7 down to 0
	localparam [31:0] BP = 32'h23EEF946;
	reg clk, rst, por, bor, master_clear_pin_n, dse, wfe, cse, wr_s, rd_s, go;
	reg [2:0] sel, fuse, cur, pins;
	reg [3:0] addr;
	reg [15:0] wdata, exp_st, rv;
	reg [31:0] seed;
	wire [15:0] rdata;
	wire [7:0] ev;
	wire [2:0] osc;
	wire msr, pro, wde, pms, rsb, load;
	integer miscompares, n_tests, i, j;
	rsc_src_model u_src (.CLK(clk), .go(go), .sel(sel), .ev(ev));
	rsc_top DUT (.CLK(clk), .RST(rst), .POWER_ON_DETECT(por),
		.BROWNOUT_DETECT(bor), .MASTER_CLEAR_PIN_N(master_clear_pin_n),
		.SOFTWARE_RESET_INSTR(ev[0]), .WATCHDOG_TIMEOUT(ev[1]),
		.CONFIG_MISMATCH(ev[2]), .TRAP_CONFLICT(ev[3]),
		.ILLEGAL_OPCODE(ev[4]), .UNINIT_WREG_RESET(ev[5]),
		.SLEEP_ENTER(ev[6]), .IDLE_ENTER(ev[7]), .DEEP_SLEEP_ENABLE(dse),
		.WATCHDOG_FUSE_ENABLE(wfe), .CLOCK_SWITCH_ENABLE(cse),
		.INITIAL_OSC_SELECT_FUSE(fuse), .CURRENT_OSC_FIELD(cur),
		.ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
		.MASTER_SYSTEM_RESET(msr), .POR_ONLY_RESET(pro),
		.WATCHDOG_ENABLE(wde), .PROGMEM_SLEEP_POWER(pms),
		.REGULATOR_STANDBY(rsb), .OSC_SELECT(osc), .OSC_SELECT_LOAD(load));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task chk(input string nm, input [15:0] e, input [15:0] g);
		n_tests = n_tests + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Bit 10 only clears; bits 13..11 never stick
	task wr(input [15:0] d);
		addr <= 4'h0;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		exp_st = (d & 16'hC3FF) | (exp_st & d & 16'h0400);
	endtask
	task rd(input [3:0] a);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk) rv = rdata;
		@(posedge clk);
	endtask
	task cst;
		rd(4'h0);
		chk("status", exp_st, rv);
	endtask
	// Bounded wait for the end of reset
	task settle;
		for (i = 0; i < 12 && msr !== 1'b0; i = i + 1)
			@(negedge clk);
		if (msr !== 1'b0) begin
			miscompares = miscompares + 1;
			final_report;
		end
		@(posedge clk);
	endtask
	task fire(input [2:0] k);
		sel <= k;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		if (k >= 3'h6)
			exp_st = exp_st & 16'hFFEF;
		exp_st = exp_st | (16'h0001 << BP[k*4 +: 4]);
		if (k == 3'h6 && dse)
			exp_st = exp_st | 16'h0400;
		@(negedge clk) chk("reset", {15'h0, k < 3'h6}, {15'h0, msr});
		@(negedge clk) chk("load", {15'h0, k < 3'h6}, {15'h0, load});
		settle;
	endtask
	// Pin levels as {power-on, brown-out, clear pin}
	task pin(input [2:0] w);
		pins <= w;
		repeat (4) @(posedge clk);
		@(negedge clk) chk("pinrst", 16'h1, {15'h0, msr});
		chk("poronly", {15'h0, w == 3'b101}, {15'h0, pro});
		@(posedge clk);
		// Live sources word while the pin level still stands
		rd(4'h1);
		chk("sources", {11'h0, w[1], 2'h0, ~w[0], w[2]}, rv);
		exp_st = w[2] ? 16'h0003 : exp_st | (w[1] ? 16'h2 : 16'h80);
		pins <= 3'b001;
		settle;
	endtask
	always @* {por, bor, master_clear_pin_n} = pins;
	initial begin
		miscompares = 0;
		n_tests = 0;
		seed = 32'h1D47;
		{rst, pins, go, sel, dse, wfe, cse} = {1'b1, 3'b001, 7'h0};
		{fuse, cur, addr, wdata, wr_s, rd_s} = {3'h5, 3'h2, 22'h0};
		exp_st = 16'h0003;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		cst;
		wr(16'hFFFF);
		cst;
		chk("bias", 16'h1, {15'h0, pms});
		chk("wdten", 16'h1, {15'h0, wde});
		wr(16'h0000);
		cst;
		chk("stby", 16'h1, {15'h0, rsb});
		// Fuse is sampled at the next edge, the enable follows it
		wfe <= 1'b1;
		@(posedge clk);
		@(negedge clk) chk("wdfuse", 16'h1, {15'h0, wde});
		@(posedge clk);
		wfe <= 1'b0;
		rd(4'h7);
		chk("unmapped", 16'h0, rv);
		chk("wdoff", 16'h0, {15'h0, wde});
		$display("test registers done");
		for (j = 0; j < 8; j = j + 1) begin
			fire(j[2:0]);
			cst;
			wr(16'h0000);
		end
		dse <= 1'b1;
		fire(3'h6);
		cst;
		wr(16'h0400);
		cst;
		fire(3'h1);
		fire(3'h7);
		cst;
		sel <= 3'h3;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		wr(16'h0000);
		exp_st = 16'h8000;
		settle;
		cst;
		$display("test events done");
		pin(3'b000);
		pin(3'b011);
		cst;
		pin(3'b101);
		cst;
		$display("test pins done");
		fire(3'h0);
		chk("osc", 16'h5, {13'h0, osc});
		cse <= 1'b1;
		fire(3'h1);
		chk("osc", 16'h2, {13'h0, osc});
		pin(3'b011);
		chk("osc", 16'h5, {13'h0, osc});
		$display("test clock done");
		for (j = 0; j < 8; j = j + 1) begin
			seed = xs(seed);
			wr(seed[15:0]);
			cst;
			chk("bias", {15'h0, exp_st[8]}, {15'h0, pms});
			chk("stby", {15'h0, ~exp_st[8]}, {15'h0, rsb});
			chk("wdten", {15'h0, exp_st[5]}, {15'h0, wde});
		end
		$display("test random done");
		final_report;
	end
endmodule
